// File: common/cmp_one_pkg.sv
// constants shared by the first comparator control block
package cmp_one_pkg;

  // register map: the printed offset is an index, the bus sees four times it
  localparam int unsigned ADDR_W              = 12;
  localparam logic [11:0] CTRL_INDEX          = 12'h119;
  localparam logic [11:0] CTRL_BYTE_ADDR      = 12'(CTRL_INDEX * 4);
  localparam int unsigned DATA_W              = 32;
  localparam int unsigned REG_W               = 8;

  // control register field positions
  localparam int unsigned CHANNEL_LSB         = 0;
  localparam int unsigned CHANNEL_MSB         = 1;
  localparam int unsigned REF_SEL_BIT         = 2;
  localparam int unsigned SPEED_BIT           = 3;
  localparam int unsigned INVERT_BIT          = 4;
  localparam int unsigned PIN_OE_BIT          = 5;
  localparam int unsigned RESULT_BIT          = 6;
  localparam int unsigned ENABLE_BIT          = 7;

  // reset value and the mask of bits that software may write
  localparam logic [7:0]  CTRL_RESET          = 8'h00;
  localparam logic [7:0]  CTRL_WRITE_MASK     = 8'hBF;

  // one instruction cycle is four oscillator clocks
  localparam int unsigned INSTR_CYCLE_CLKS    = 4;

  // bus response codes
  localparam logic [1:0]  RESP_OKAY           = 2'h0;
  localparam logic [1:0]  RESP_SLVERR         = 2'h2;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'h0,
    WR_RESP    = 2'h1
  } wr_state_t;

  typedef enum logic {
    RD_IDLE = 1'h0,
    RD_RESP = 1'h1
  } rd_state_t;

endpackage

// File: hw/comparator_one_control.sv
// control register and output conditioning for the first comparator
//
// Overview of operation
// - bit 7 of the control register switches the comparator on when 1 and off when 0.
// - bits 1:0 route one of four analog pins to the inverting input, codes 00 to 11 in order.
// - bit 2 picks the internal reference (1) or the external positive pin (0).
// - bit 6 reads back the comparator result, read only, with no pin needed.
// - with bit 4 clear the result is 1 when the non-inverting input is higher; set inverts it.
// - the readable result is latched each instruction cycle; the pin follows it unlatched.
// - the change event does not depend on the pin output enable.
// - the pin is driven only with output enable, enable and a port direction of output.
// - bit 5 set presents the result on the pin, clear keeps it internal.
// - bit 3 set gives normal speed, clear gives slow low-power operation.
`timescale 1ns/1ps
module comparator_one_control (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // analog core
  input  wire logic        raw_compare,
  output logic             cmp_enable_bit,
  output logic [1:0]       cmp_channel_select,
  output logic             cmp_reference_select,
  output logic             cmp_speed_select,
  // output pin and change event
  input  wire logic        port_a_direction,
  output logic             cmp_pin_out,
  output logic             cmp_pin_oe,
  output logic             cmp_change_pulse
);

  logic [7:0]  ctrl_ff;
  logic [7:0]  nxt_ctrl;
  logic        result_latched_ff;
  logic        nxt_result_latched;
  logic        pin_out_ff;
  logic        pin_oe_ff;
  logic        change_ff;
  logic        result_now;
  logic        tick;

  cmp_one_pkg::wr_state_t wr_state_ff;
  cmp_one_pkg::wr_state_t nxt_wr_state;
  logic        awready_ff;
  logic        nxt_awready;
  logic        wready_ff;
  logic        nxt_wready;
  logic        aw_have_ff;
  logic        nxt_aw_have;
  logic        w_have_ff;
  logic        nxt_w_have;
  logic [11:0] waddr_ff;
  logic [11:0] nxt_waddr;
  logic [31:0] wdata_ff;
  logic [31:0] nxt_wdata;
  logic [3:0]  wstrb_ff;
  logic [3:0]  nxt_wstrb;
  logic        bvalid_ff;
  logic        nxt_bvalid;
  logic [1:0]  bresp_ff;
  logic [1:0]  nxt_bresp;
  logic        wr_commit;
  logic        wr_hit;

  cmp_one_pkg::rd_state_t rd_state_ff;
  cmp_one_pkg::rd_state_t nxt_rd_state;
  logic        arready_ff;
  logic        nxt_arready;
  logic        rvalid_ff;
  logic        nxt_rvalid;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic [1:0]  rresp_ff;
  logic [1:0]  nxt_rresp;
  logic        rd_hit;

  instr_cycle_divider #(
    .DIV (cmp_one_pkg::INSTR_CYCLE_CLKS)
  ) u_div (
    .aclk    (aclk),
    .aresetn (aresetn),
    .tick    (tick)
  );

  // a disabled comparator reads as a low comparison before polarity
  assign result_now = (raw_compare & ctrl_ff[cmp_one_pkg::ENABLE_BIT])
                      ^ ctrl_ff[cmp_one_pkg::INVERT_BIT];

  // write channel
  assign wr_commit = (wr_state_ff == cmp_one_pkg::WR_COLLECT) && aw_have_ff && w_have_ff;
  assign wr_hit    = (waddr_ff[11:2] == cmp_one_pkg::CTRL_BYTE_ADDR[11:2]);

  always_comb begin
    nxt_wr_state = wr_state_ff;
    nxt_awready  = awready_ff;
    nxt_wready   = wready_ff;
    nxt_aw_have  = aw_have_ff;
    nxt_w_have   = w_have_ff;
    nxt_waddr    = waddr_ff;
    nxt_wdata    = wdata_ff;
    nxt_wstrb    = wstrb_ff;
    nxt_bvalid   = bvalid_ff;
    nxt_bresp    = bresp_ff;
    nxt_ctrl     = ctrl_ff;
    unique case (wr_state_ff)
      cmp_one_pkg::WR_COLLECT: begin
        // address and data may arrive in either order
        if (s_axi_awvalid && awready_ff) begin
          nxt_awready = 1'b0;
          nxt_aw_have = 1'b1;
          nxt_waddr   = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_ff) begin
          nxt_wready = 1'b0;
          nxt_w_have = 1'b1;
          nxt_wdata  = s_axi_wdata;
          nxt_wstrb  = s_axi_wstrb;
        end
        if (wr_commit) begin
          nxt_aw_have  = 1'b0;
          nxt_w_have   = 1'b0;
          nxt_bvalid   = 1'b1;
          nxt_wr_state = cmp_one_pkg::WR_RESP;
          if (wr_hit) begin
            nxt_bresp = cmp_one_pkg::RESP_OKAY;
            // result flag is not storage, so writes to it are dropped
            if (wstrb_ff[0]) begin
              nxt_ctrl = (ctrl_ff & ~cmp_one_pkg::CTRL_WRITE_MASK)
                         | (wdata_ff[7:0] & cmp_one_pkg::CTRL_WRITE_MASK);
            end
          end else begin
            nxt_bresp = cmp_one_pkg::RESP_SLVERR;
          end
        end
      end
      cmp_one_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          nxt_bvalid   = 1'b0;
          nxt_awready  = 1'b1;
          nxt_wready   = 1'b1;
          nxt_wr_state = cmp_one_pkg::WR_COLLECT;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_ff <= cmp_one_pkg::WR_COLLECT;
      awready_ff  <= 1'b1;
      wready_ff   <= 1'b1;
      aw_have_ff  <= 1'b0;
      w_have_ff   <= 1'b0;
      waddr_ff    <= '0;
      wdata_ff    <= '0;
      wstrb_ff    <= '0;
      bvalid_ff   <= 1'b0;
      bresp_ff    <= cmp_one_pkg::RESP_OKAY;
      ctrl_ff     <= cmp_one_pkg::CTRL_RESET;
    end else begin
      wr_state_ff <= nxt_wr_state;
      awready_ff  <= nxt_awready;
      wready_ff   <= nxt_wready;
      aw_have_ff  <= nxt_aw_have;
      w_have_ff   <= nxt_w_have;
      waddr_ff    <= nxt_waddr;
      wdata_ff    <= nxt_wdata;
      wstrb_ff    <= nxt_wstrb;
      bvalid_ff   <= nxt_bvalid;
      bresp_ff    <= nxt_bresp;
      ctrl_ff     <= nxt_ctrl;
    end
  end

  // read channel
  assign rd_hit = (s_axi_araddr[11:2] == cmp_one_pkg::CTRL_BYTE_ADDR[11:2]);

  always_comb begin
    nxt_rd_state = rd_state_ff;
    nxt_arready  = arready_ff;
    nxt_rvalid   = rvalid_ff;
    nxt_rdata    = rdata_ff;
    nxt_rresp    = rresp_ff;
    unique case (rd_state_ff)
      cmp_one_pkg::RD_IDLE: begin
        if (s_axi_arvalid && arready_ff) begin
          nxt_arready  = 1'b0;
          nxt_rvalid   = 1'b1;
          nxt_rd_state = cmp_one_pkg::RD_RESP;
          if (rd_hit) begin
            nxt_rresp = cmp_one_pkg::RESP_OKAY;
            nxt_rdata = {24'h000000, ctrl_ff[7], result_latched_ff, ctrl_ff[5:0]};
          end else begin
            nxt_rresp = cmp_one_pkg::RESP_SLVERR;
            nxt_rdata = 32'h00000000;
          end
        end
      end
      cmp_one_pkg::RD_RESP: begin
        if (s_axi_rready) begin
          nxt_rvalid   = 1'b0;
          nxt_arready  = 1'b1;
          nxt_rd_state = cmp_one_pkg::RD_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_ff <= cmp_one_pkg::RD_IDLE;
      arready_ff  <= 1'b1;
      rvalid_ff   <= 1'b0;
      rdata_ff    <= '0;
      rresp_ff    <= cmp_one_pkg::RESP_OKAY;
    end else begin
      rd_state_ff <= nxt_rd_state;
      arready_ff  <= nxt_arready;
      rvalid_ff   <= nxt_rvalid;
      rdata_ff    <= nxt_rdata;
      rresp_ff    <= nxt_rresp;
    end
  end

  // result conditioning
  // readable copy moves only on the cycle boundary, so a read never sees a mid-cycle glitch
  always_comb begin
    nxt_result_latched = result_latched_ff;
    if (tick) begin
      nxt_result_latched = result_now;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_latched_ff <= 1'b0;
      pin_out_ff        <= 1'b0;
      pin_oe_ff         <= 1'b0;
      change_ff         <= 1'b0;
    end else begin
      result_latched_ff <= nxt_result_latched;
      pin_out_ff        <= result_now;
      pin_oe_ff         <= ctrl_ff[cmp_one_pkg::PIN_OE_BIT] & ctrl_ff[cmp_one_pkg::ENABLE_BIT]
                           & ~port_a_direction;
      // event ignores the pin enable entirely
      change_ff         <= tick && (result_now != result_latched_ff);
    end
  end

  assign s_axi_awready        = awready_ff;
  assign s_axi_wready         = wready_ff;
  assign s_axi_bvalid         = bvalid_ff;
  assign s_axi_bresp          = bresp_ff;
  assign s_axi_arready        = arready_ff;
  assign s_axi_rvalid         = rvalid_ff;
  assign s_axi_rdata          = rdata_ff;
  assign s_axi_rresp          = rresp_ff;
  assign cmp_enable_bit       = ctrl_ff[cmp_one_pkg::ENABLE_BIT];
  assign cmp_channel_select   = ctrl_ff[cmp_one_pkg::CHANNEL_MSB:cmp_one_pkg::CHANNEL_LSB];
  assign cmp_reference_select = ctrl_ff[cmp_one_pkg::REF_SEL_BIT];
  assign cmp_speed_select     = ctrl_ff[cmp_one_pkg::SPEED_BIT];
  assign cmp_pin_out          = pin_out_ff;
  assign cmp_pin_oe           = pin_oe_ff;
  assign cmp_change_pulse     = change_ff;

  // assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_ctrl_commit;
    wr_commit && wr_hit && wstrb_ff[0];
  endsequence

  sequence s_ctrl_read;
    s_axi_arvalid && arready_ff && rd_hit;
  endsequence

  a_enable_write: assert property (s_ctrl_commit |=> cmp_enable_bit == $past(wdata_ff[7]))
    else $error("enable bit did not follow the register write");
  a_channel_write: assert property (s_ctrl_commit |=>
      cmp_channel_select == $past(wdata_ff[1:0]))
    else $error("channel select did not follow the register write");
  a_ref_write: assert property (s_ctrl_commit |=>
      cmp_reference_select == $past(wdata_ff[2]))
    else $error("reference select did not follow the register write");
  a_flag_readback: assert property (s_ctrl_read |=> s_axi_rvalid
      && s_axi_rdata[6] == $past(result_latched_ff) && s_axi_rdata[31:8] == 24'h000000)
    else $error("read data does not show the latched result");
  a_polarity_latch: assert property (tick |=> result_latched_ff
      == $past((raw_compare & ctrl_ff[7]) ^ ctrl_ff[4]))
    else $error("latched result has the wrong polarity");
  a_latch_hold: assert property (!tick |=> $stable(result_latched_ff))
    else $error("latched result moved between cycle boundaries");
  a_pin_follow: assert property (##1 cmp_pin_out == $past(result_now))
    else $error("pin does not follow the comparator directly");
  a_event_no_oe: assert property (tick && result_now != result_latched_ff
      |=> cmp_change_pulse)
    else $error("change event lost");
  a_pin_drive: assert property (##1 cmp_pin_oe == $past(ctrl_ff[5] & ctrl_ff[7]
      & ~port_a_direction))
    else $error("pin driven without all three conditions");
  a_pin_internal: assert property (!ctrl_ff[5] |=> !cmp_pin_oe)
    else $error("pin driven with output enable clear");
  a_speed_write: assert property (s_ctrl_commit |=>
      cmp_speed_select == $past(wdata_ff[3]))
    else $error("speed select did not follow the register write");
  a_reset_clear: assert property (@(posedge aclk) disable iff (1'b0)
      !aresetn |=> ctrl_ff == 8'h00 && !result_latched_ff)
    else $error("control register not cleared by reset");

endmodule

// File: hw/instr_cycle_divider.sv
// divider producing the end-of-instruction-cycle enable pulse
`timescale 1ns/1ps
module instr_cycle_divider #(
  parameter int unsigned DIV = cmp_one_pkg::INSTR_CYCLE_CLKS
) (
  // clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // one-cycle pulse on the last clock of each cycle
  output logic      tick
);

  localparam int unsigned CNT_W = (DIV > 1) ? $clog2(DIV) : 1;
  localparam logic [CNT_W-1:0] LAST = CNT_W'(DIV - 1);

  logic [CNT_W-1:0] count_ff;
  logic [CNT_W-1:0] nxt_count;

  always_comb begin
    if (count_ff == LAST) begin
      nxt_count = '0;
    end else begin
      nxt_count = count_ff + CNT_W'(1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_ff <= '0;
    end else begin
      count_ff <= nxt_count;
    end
  end

  assign tick = (count_ff == LAST);

endmodule

// File: sim/testbench.sv
// self-checking bench for the first comparator control block
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [7:0] wv;
    logic       raw;
    logic       dir;
    logic [7:0] rd;
    logic       pin;
    logic       oe;
  } row_t;

  logic        aclk;
  logic        aresetn;
  logic [11:0] awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [11:0] araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        raw_compare;
  logic        cmp_enable_bit;
  logic [1:0]  cmp_channel_select;
  logic        cmp_reference_select;
  logic        cmp_speed_select;
  logic        port_a_direction;
  logic        cmp_pin_out;
  logic        cmp_pin_oe;
  logic        cmp_change_pulse;
  int          failures;
  int          compares;
  localparam logic [11:0] CTRL = cmp_one_pkg::CTRL_BYTE_ADDR;
  // every channel code, disabled-with-invert, and a write to the read-only flag
  row_t rows [0:9] = '{
    '{8'h80, 1'h1, 1'h0, 8'hC0, 1'h1, 1'h0}, '{8'hA0, 1'h1, 1'h0, 8'hE0, 1'h1, 1'h1},
    '{8'hA0, 1'h1, 1'h1, 8'hE0, 1'h1, 1'h0}, '{8'hB0, 1'h1, 1'h0, 8'hB0, 1'h0, 1'h1},
    '{8'h30, 1'h1, 1'h0, 8'h70, 1'h1, 1'h0}, '{8'h8F, 1'h0, 1'h0, 8'h8F, 1'h0, 1'h0},
    '{8'h85, 1'h1, 1'h0, 8'hC5, 1'h1, 1'h0}, '{8'h82, 1'h0, 1'h0, 8'h82, 1'h0, 1'h0},
    '{8'h98, 1'h0, 1'h0, 8'hD8, 1'h1, 1'h0}, '{8'hFF, 1'h1, 1'h0, 8'hBF, 1'h0, 1'h1}};

  comparator_one_control dut_u (
    .aclk                 (aclk),
    .aresetn              (aresetn),
    .s_axi_awaddr         (awaddr),
    .s_axi_awprot         (3'h0),
    .s_axi_awvalid        (awvalid),
    .s_axi_awready        (awready),
    .s_axi_wdata          (wdata),
    .s_axi_wstrb          (wstrb),
    .s_axi_wvalid         (wvalid),
    .s_axi_wready         (wready),
    .s_axi_bresp          (bresp),
    .s_axi_bvalid         (bvalid),
    .s_axi_bready         (bready),
    .s_axi_araddr         (araddr),
    .s_axi_arprot         (3'h0),
    .s_axi_arvalid        (arvalid),
    .s_axi_arready        (arready),
    .s_axi_rdata          (rdata),
    .s_axi_rresp          (rresp),
    .s_axi_rvalid         (rvalid),
    .s_axi_rready         (rready),
    .raw_compare          (raw_compare),
    .cmp_enable_bit       (cmp_enable_bit),
    .cmp_channel_select   (cmp_channel_select),
    .cmp_reference_select (cmp_reference_select),
    .cmp_speed_select     (cmp_speed_select),
    .port_a_direction     (port_a_direction),
    .cmp_pin_out          (cmp_pin_out),
    .cmp_pin_oe           (cmp_pin_oe),
    .cmp_change_pulse     (cmp_change_pulse)
  );

  initial begin
    aclk = 1'h0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("BAD at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // a hang on the bus counts as a mismatch and closes the run
  task automatic hang(input int n);
    if (n > 40) begin
      failures++;
      $display("BAD at %0t got %h expected %h", $time, 32'h0, 32'h1);
      test_done();
    end
  endtask

  task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                           output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'h0;
        break;
      end
      n++;
      hang(n);
    end
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'h0;
        break;
      end
      n++;
      hang(n);
    end
  endtask

  initial begin
    logic [31:0] d;
    logic [1:0]  r;
    int          n;
    failures = 0;
    compares = 0;
    aresetn = 1'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    raw_compare = 1'h0;
    port_a_direction = 1'h1;
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    axi_read(CTRL, d, r);
    check(d, 32'h0);
    check({cmp_enable_bit, cmp_pin_oe, cmp_pin_out, cmp_change_pulse}, 4'h0);
    $display("test reset done");

    for (int i = 0; i < 10; i++) begin
      // the bench plays software, so the analog pin setup is taken as done
      axi_write(CTRL, {24'h0, rows[i].wv}, 4'hF, r);
      check(r, cmp_one_pkg::RESP_OKAY);
      raw_compare <= rows[i].raw;
      port_a_direction <= rows[i].dir;
      repeat (8) @(posedge aclk);
      check(cmp_pin_out, rows[i].pin);
      check(cmp_pin_oe, rows[i].oe);
      check(cmp_enable_bit, rows[i].wv[7]);
      check(cmp_channel_select, rows[i].wv[1:0]);
      check(cmp_reference_select, rows[i].wv[2]);
      check(cmp_speed_select, rows[i].wv[3]);
      axi_read(CTRL, d, r);
      check(d, {24'h0, rows[i].rd});
      check(r, cmp_one_pkg::RESP_OKAY);
    end
    $display("test rows done");

    // unmapped place and empty strobe must leave the register alone
    axi_write(12'h468, 32'hFF, 4'hF, r);
    check(r, cmp_one_pkg::RESP_SLVERR);
    axi_read(12'h468, d, r);
    check(r, cmp_one_pkg::RESP_SLVERR);
    check(d, 32'h0);
    axi_write(CTRL, 32'h0, 4'h0, r);
    check(r, cmp_one_pkg::RESP_OKAY);
    axi_read(CTRL, d, r);
    check(d, 32'hBF);
    $display("test refusals done");

    // change event with pin output on, then off
    for (int k = 0; k < 2; k++) begin
      axi_write(CTRL, (k == 0) ? 32'hA0 : 32'h80, 4'hF, r);
      raw_compare <= 1'h0;
      port_a_direction <= 1'h0;
      repeat (8) @(posedge aclk);
      raw_compare <= 1'h1;
      // count from the first edge: the boundary may fall right after the input moves
      n = 0;
      for (int j = 0; j < 10; j++) begin
        @(posedge aclk);
        if (j == 1) check(cmp_pin_out, 1'h1);
        if (cmp_change_pulse === 1'h1) n++;
      end
      check(n, 1);
      axi_read(CTRL, d, r);
      check(d, (k == 0) ? 32'hE0 : 32'hC0);
    end
    $display("test change done");

    // second reset in mid-run
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    axi_read(CTRL, d, r);
    check(d, 32'h0);
    check(cmp_pin_oe, 1'h0);
    $display("test second reset done");
    test_done();
  end
endmodule
